/* File: common/apm_pkg.sv */
// Package with constants and types for the address/data pin mux and strap decode
package apm_pkg;

  // ==========================================================
  // Control bit positions
  localparam int unsigned APM_FLAG_MODE_BIT = 20;

  // ==========================================================
  // Boot strap encodings
  localparam logic [1:0] APM_BOOT_SPI_SLAVE = 2'h0;
  localparam logic [1:0] APM_BOOT_SPI_MASTER = 2'h1;
  localparam logic [1:0] APM_BOOT_EPROM = 2'h2;
  localparam logic [1:0] APM_BOOT_ROM = 2'h3;

  // ==========================================================
  // Clock ratio strap encodings and decoded ratios
  localparam logic [1:0] APM_CLK_3X = 2'h0;
  localparam logic [1:0] APM_CLK_16X = 2'h1;
  localparam logic [1:0] APM_CLK_8X = 2'h2;
  localparam logic [4:0] APM_RATIO_3 = 5'h03;
  localparam logic [4:0] APM_RATIO_16 = 5'h10;
  localparam logic [4:0] APM_RATIO_8 = 5'h08;
  localparam logic [4:0] APM_RATIO_NONE = 5'h00;

  // ==========================================================
  // Reset values
  localparam logic [15:0] APM_PINS_RST = 16'h0000;
  localparam logic [15:0] APM_OE_RST_N = 16'hFFFF;
  localparam logic APM_ALE_RST = 1'b0;
  localparam logic APM_STROBE_N_RST = 1'b1;
  localparam logic APM_FLAG_MODE_RST = 1'b0;

  // ==========================================================
  // Pin direction codes
  localparam logic [15:0] APM_OE_DRIVE_N = 16'h0000;

  typedef enum logic [1:0] {
    APM_BOOT_MODE_SPI_SLAVE,
    APM_BOOT_MODE_SPI_MASTER,
    APM_BOOT_MODE_EPROM,
    APM_BOOT_MODE_ROM
  } apm_boot_e;

endpackage : apm_pkg

/* File: core/apm_pin_mux.sv */
// Address/data pin multiplexer, flag remap and strap decoder
// Pin phase map, upper pin byte / lower pin byte:
//   8-bit, strobe high  : address 23:16 / address 15:8
//   8-bit, strobe low   : address 7:0 / data 7:0
//   16-bit, strobe high : address 15:8 / address 7:0
//   16-bit, strobe low  : data 15:8 / data 7:0
//   flag mode           : flags 7:0 / flags 15:8
//
// Direction: every address phase and every write data phase drives the
// pins; a read data phase releases them so the memory can answer. In flag
// mode each pin follows the drive enable of the flag mapped onto it.
//
// Strobes never float. In flag mode they rest at their idle levels, so an
// external latch or memory on the shared pins never sees a stray cycle.
//
// Straps load on every edge in reset; the last edge in reset wins and the
// value holds until the next reset. The ratio output only reports the
// start-up choice: later frequency changes belong to power management.
module apm_pin_mux
  import apm_pkg::*;
#(
  parameter int unsigned ADDR_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] system_control_reg_i,
  input wire logic pp_enable_i,
  input wire logic pp_mode16_i,
  input wire logic pp_ale_i,
  input wire logic pp_rd_n_i,
  input wire logic pp_wr_n_i,
  input wire logic [ADDR_W-1:0] pp_addr_i,
  input wire logic [15:0] pp_wdata_i,
  input wire logic pp_drive_i,
  output logic [15:0] pp_rdata_o,
  input wire logic [15:0] muxed_addr_data_pins_i,
  output logic [15:0] muxed_addr_data_pins_o,
  output logic [15:0] muxed_addr_data_pins_oe_n_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  input wire logic [15:0] gp_flag_out_i,
  input wire logic [15:0] gp_flag_drive_i,
  output logic [15:0] gp_flag_pins_o,
  output logic flag_mode_o,
  input wire logic [1:0] boot_select_strap_i,
  input wire logic [1:0] clock_ratio_strap_i,
  output apm_boot_e boot_mode_o,
  output logic [4:0] clock_ratio_o,
  output logic clock_ratio_bad_o
);

  // ==========================================================
  // Decode helpers
  function automatic apm_boot_e boot_decode(input logic [1:0] code);
    case (code)
      APM_BOOT_SPI_SLAVE: boot_decode = APM_BOOT_MODE_SPI_SLAVE;
      APM_BOOT_SPI_MASTER: boot_decode = APM_BOOT_MODE_SPI_MASTER;
      APM_BOOT_EPROM: boot_decode = APM_BOOT_MODE_EPROM;
      default: boot_decode = APM_BOOT_MODE_ROM;
    endcase
  endfunction : boot_decode

  function automatic logic [4:0] ratio_decode(input logic [1:0] code);
    case (code)
      APM_CLK_3X: ratio_decode = APM_RATIO_3;
      APM_CLK_16X: ratio_decode = APM_RATIO_16;
      APM_CLK_8X: ratio_decode = APM_RATIO_8;
      default: ratio_decode = APM_RATIO_NONE;
    endcase
  endfunction : ratio_decode

  // Swap the two pin bytes; pin/flag mapping is its own inverse
  function automatic logic [15:0] byte_swap(input logic [15:0] v);
    byte_swap = {v[7:0], v[15:8]};
  endfunction : byte_swap

  logic flag_mode;
  logic [15:0] pin_value;
  logic [15:0] flag_oe_n;
  logic [15:0] oe_n_next;
  logic ale_next;
  logic rd_n_next;
  logic wr_n_next;
  logic [15:0] rdata_next;
  apm_boot_e boot_next;
  logic [4:0] ratio_next;
  logic ratio_bad_next;

  // ==========================================================
  // Mode decode
  // Flag mode needs both conditions; a stray bit alone keeps the port
  assign flag_mode = system_control_reg_i[APM_FLAG_MODE_BIT] & ~pp_enable_i;

  // ==========================================================
  // Pin phase selection
  // Priority: flag mode first, then data width, then strobe phase
  always_comb begin
    if (flag_mode) begin
      pin_value = byte_swap(gp_flag_out_i);
    end else if (!pp_mode16_i && pp_ale_i) begin
      pin_value = {pp_addr_i[23:16], pp_addr_i[15:8]};
    end else if (!pp_mode16_i) begin
      pin_value = {pp_addr_i[7:0], pp_wdata_i[7:0]};
    end else if (pp_ale_i) begin
      pin_value = pp_addr_i[15:0];
    end else begin
      pin_value = pp_wdata_i;
    end
  end

  // ==========================================================
  // Pin direction
  // Flag direction follows the same byte swap as the data
  assign flag_oe_n = ~byte_swap(gp_flag_drive_i);

  // Read data phase releases the pins so the memory can answer;
  // a write data phase keeps driving so the memory sees stable data
  always_comb begin
    if (flag_mode) begin
      oe_n_next = flag_oe_n;
    end else if (pp_ale_i || pp_drive_i) begin
      oe_n_next = APM_OE_DRIVE_N; // Address phase always driven
    end else begin
      oe_n_next = APM_OE_RST_N; // Read phase: release pins
    end
  end

  // ==========================================================
  // Strobe next values
  // Idle levels in flag mode, so the latch never catches a flag pattern
  always_comb begin
    if (flag_mode) begin
      ale_next = APM_ALE_RST;
      rd_n_next = APM_STROBE_N_RST;
      wr_n_next = APM_STROBE_N_RST;
    end else begin
      ale_next = pp_ale_i;
      rd_n_next = pp_rd_n_i;
      wr_n_next = pp_wr_n_i;
    end
  end

  // ==========================================================
  // Inbound data view
  // 8-bit reads only carry data on the lower byte; upper byte is zeroed
  always_comb begin
    if (pp_mode16_i) begin
      rdata_next = muxed_addr_data_pins_i;
    end else begin
      rdata_next = {8'h00, muxed_addr_data_pins_i[7:0]};
    end
  end

  // ==========================================================
  // Strap decode
  // Purely combinational; the capture below decides when it counts
  always_comb begin
    boot_next = boot_decode(boot_select_strap_i);
    ratio_next = ratio_decode(clock_ratio_strap_i);
    ratio_bad_next = &clock_ratio_strap_i;
  end

  // ==========================================================
  // Registered pin outputs
  // Value and direction move on one edge, so no half-turned bus reaches the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      muxed_addr_data_pins_o <= APM_PINS_RST;
      muxed_addr_data_pins_oe_n_o <= APM_OE_RST_N;
    end else begin
      muxed_addr_data_pins_o <= pin_value;
      muxed_addr_data_pins_oe_n_o <= oe_n_next;
    end
  end

  // Strobes have no enable at all: always driven, idle inactive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ale_o <= APM_ALE_RST;
      rd_n_o <= APM_STROBE_N_RST;
      wr_n_o <= APM_STROBE_N_RST;
    end else begin
      ale_o <= ale_next;
      rd_n_o <= rd_n_next;
      wr_n_o <= wr_n_next;
    end
  end

  // ==========================================================
  // Inbound data and flag views
  // Flags are read back in every mode; only flag mode gives them meaning
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pp_rdata_o <= APM_PINS_RST;
      gp_flag_pins_o <= APM_PINS_RST;
      flag_mode_o <= APM_FLAG_MODE_RST;
    end else begin
      pp_rdata_o <= rdata_next;
      gp_flag_pins_o <= byte_swap(muxed_addr_data_pins_i);
      flag_mode_o <= flag_mode;
    end
  end

  // ==========================================================
  // Strap capture: loaded on every edge in reset, frozen after release
  // Ratio is start-up only; later changes belong to power management
  // Last edge in reset wins, so straps must settle before reset ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_mode_o <= boot_next;
      clock_ratio_o <= ratio_next;
      clock_ratio_bad_o <= ratio_bad_next;
    end
  end

endmodule : apm_pin_mux

/* File: testbench/apm_mem_model.sv */
// External address latch and parallel memory model
module apm_mem_model (
  input wire logic clk_i, ale_i, rd_n_i,
  input wire logic [15:0] pins_i, oe_n_i,
  output logic [15:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] latch_reg;
  // Latch loads the pins on every edge while the strobe is high and holds the last address once it drops
  always_ff @(posedge clk_i) if (ale_i) latch_reg <= pins_i;
  // Released lines sit at pull-up level unless memory answers; data is inverted address
  assign pins_o = (~oe_n_i & pins_i) | (oe_n_i & (rd_n_i ? 16'hFFFF : ~latch_reg));
endmodule : apm_mem_model

/* File: testbench/apm_pin_mux_monitor.sv */
// Checker for the address/data pin mux
module apm_pin_mux_monitor #(
  parameter int unsigned ADDR_W = 24
) (
  input wire logic clk_i, rst_i, pp_enable_i, pp_mode16_i, pp_ale_i, pp_rd_n_i, pp_wr_n_i,
  input wire logic [31:0] system_control_reg_i,
  input wire logic [ADDR_W-1:0] pp_addr_i,
  input wire logic [15:0] pp_wdata_i, muxed_addr_data_pins_o, gp_flag_out_i,
  input wire logic pp_drive_i, ale_o, rd_n_o, wr_n_o, flag_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Mode helpers
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire fm = system_control_reg_i[20] && !pp_enable_i;
  wire p8 = !rst_i && !fm && !pp_mode16_i;
  wire p16 = !rst_i && !fm && pp_mode16_i;
  wire [15:0] po = muxed_addr_data_pins_o;
  // Flags land swapped by byte on the pins
  wire [15:0] fsw = {gp_flag_out_i[7:0], gp_flag_out_i[15:8]};
  chk_flag_enter: assert property (!$past(rst_i) |-> flag_mode_o == $past(fm))
    else $error("flag mode state wrong");
  chk_flag_drive: assert property ($past(!rst_i && fm) |-> po == $past(fsw))
    else $error("flag to pin map wrong");
  chk_a8_addr: assert property ($past(p8 && pp_ale_i) |-> po == $past(pp_addr_i[23:8]))
    else $error("8-bit address phase wrong");
  chk_a8_data: assert property ($past(p8 && !pp_ale_i && pp_drive_i) |->
    po == {$past(pp_addr_i[7:0]), $past(pp_wdata_i[7:0])}) else $error("8-bit data phase wrong");
  chk_a16_addr: assert property ($past(p16 && pp_ale_i) |-> po == $past(pp_addr_i[15:0]))
    else $error("16-bit address phase wrong");
  chk_a16_data: assert property ($past(p16 && !pp_ale_i && pp_drive_i) |->
    po == $past(pp_wdata_i)) else $error("16-bit data phase wrong");
  chk_strobe_follow: assert property ($past(!rst_i && !fm) |->
    {ale_o, rd_n_o, wr_n_o} == $past({pp_ale_i, pp_rd_n_i, pp_wr_n_i})) else $error("strobe lost");
  chk_strobe_idle: assert property ($past(!rst_i && fm) |-> {ale_o, rd_n_o, wr_n_o} == 3'h3)
    else $error("strobe not idle in flag mode");
endmodule : apm_pin_mux_monitor

bind apm_pin_mux apm_pin_mux_monitor #(.ADDR_W(ADDR_W)) mon_u (.clk_i, .rst_i, .pp_enable_i,
  .pp_mode16_i, .pp_ale_i, .pp_rd_n_i, .pp_wr_n_i, .system_control_reg_i, .pp_addr_i, .pp_wdata_i,
  .muxed_addr_data_pins_o, .gp_flag_out_i, .pp_drive_i, .ale_o, .rd_n_o, .wr_n_o, .flag_mode_o);

/* File: testbench/apm_pin_mux_tb.sv */
// Self-checking bench for the pin mux and strap decode
module apm_pin_mux_tb;
  import apm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, en = 0, m16 = 0, ale = 0, rdn = 1, wrn = 1, drv = 0;
  logic [31:0] sys = 32'h0;
  logic [23:0] addr = 24'h0;
  logic [15:0] wd = 16'h0, fo = 16'h0, fd = 16'h0, rdat, pi, po, oe, fp;
  logic [1:0] bs = 2'h0, cs = 2'h0;
  logic ale_o, rd_n_o, wr_n_o, fm_o, bad_o;
  logic [4:0] ratio;
  apm_boot_e boot;
  int bad_count = 0, comparisons = 0, cyc = 0;
  always #4 clk_i = ~clk_i;
  apm_pin_mux dut_u (.clk_i, .rst_i, .system_control_reg_i(sys), .pp_enable_i(en),
    .pp_mode16_i(m16), .pp_ale_i(ale), .pp_rd_n_i(rdn), .pp_wr_n_i(wrn), .pp_addr_i(addr),
    .pp_wdata_i(wd), .pp_drive_i(drv), .pp_rdata_o(rdat), .muxed_addr_data_pins_i(pi),
    .muxed_addr_data_pins_o(po), .muxed_addr_data_pins_oe_n_o(oe), .ale_o, .rd_n_o, .wr_n_o,
    .gp_flag_out_i(fo), .gp_flag_drive_i(fd), .gp_flag_pins_o(fp), .flag_mode_o(fm_o),
    .boot_select_strap_i(bs), .clock_ratio_strap_i(cs), .boot_mode_o(boot),
    .clock_ratio_o(ratio), .clock_ratio_bad_o(bad_o));
  apm_mem_model mem_u (.clk_i, .ale_i(ale_o), .rd_n_i(rd_n_o), .pins_i(po), .oe_n_i(oe),
    .pins_o(pi));
  task automatic step(); @(posedge clk_i); #1; endtask : step
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic summarize();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Straps must survive a change right after reset
  task automatic t_strap();
    logic [4:0] rt [4] = '{5'h03, 5'h10, 5'h08, 5'h00};
    apm_boot_e bm [4] = '{APM_BOOT_MODE_SPI_SLAVE, APM_BOOT_MODE_SPI_MASTER,
      APM_BOOT_MODE_EPROM, APM_BOOT_MODE_ROM};
    for (int c = 0; c < 4; c++) begin
      bs = 2'(c);
      cs = 2'(c);
      rst_i = 1;
      step();
      step();
      rst_i = 0;
      bs = ~bs;
      cs = ~cs;
      step();
      cmp(16'(boot), 16'(bm[c]));
      cmp(16'(ratio), 16'(rt[c]));
      cmp(16'(bad_o), 16'(c == 3));
    end
  endtask : t_strap
  // Address then data phases back to back, then a read through the latch
  task automatic t_port();
    ale = 1;
    addr = 24'hABCDEF;
    wd = 16'hC012;
    step();
    cmp(po, 16'hABCD);
    cmp(oe, 16'h0000);
    cmp(16'({ale_o, rd_n_o, wr_n_o}), 16'h7);
    ale = 0;
    drv = 1;
    wrn = 0;
    step();
    cmp(po, 16'hEF12);
    cmp(16'({ale_o, rd_n_o, wr_n_o}), 16'h2);
    wrn = 1;
    m16 = 1;
    ale = 1;
    step();
    cmp(po, 16'hCDEF);
    ale = 0;
    step();
    cmp(po, 16'hC012);
    cmp(oe, 16'h0000);
    drv = 0;
    rdn = 0;
    step();
    cmp(oe, 16'hFFFF);
    step();
    cmp(rdat, 16'h3210);
    // 8-bit read: only the lower pin byte carries data
    rdn = 1;
    m16 = 0;
    ale = 1;
    step();
    ale = 0;
    rdn = 0;
    step();
    step();
    cmp(rdat, 16'h0032);
    rdn = 1;
  endtask : t_port
  // Flag mode needs both the control bit and a disabled port
  task automatic t_flag();
    sys = 32'h0010_0000;
    en = 1;
    step();
    cmp(16'(fm_o), 16'h0);
    en = 0;
    ale = 1;
    fo = 16'h1234;
    fd = 16'h00FF;
    step();
    cmp(16'(fm_o), 16'h1);
    cmp(po, 16'h3412);
    cmp(oe, 16'h00FF);
    cmp(16'({ale_o, rd_n_o, wr_n_o}), 16'h3);
    step();
    cmp(fp, 16'hFF34);
    sys = 32'h0;
    ale = 0;
  endtask : t_flag
  // Hang guard, far beyond the 27 cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    step();
    step();
    rst_i = 0;
    step();
    cmp(16'({ale_o, rd_n_o, wr_n_o}), 16'h3);
    t_strap();
    t_port();
    t_flag();
    summarize();
  end
endmodule : apm_pin_mux_tb
